// >>> rtl/svm_pkg.sv
// ==================================================
// Supply monitor shared definitions
package svm_pkg;

	// ==================================================
	// Register bus
	localparam int unsigned AXI_AW = 12;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==================================================
	// Register indices and byte addresses
	localparam logic [7:0] CON0_IDX = 8'h4a;
	localparam logic [7:0] CON1_IDX = 8'h4b;
	localparam logic [AXI_AW-1:0] CON0_ADDR = {2'h0, CON0_IDX, 2'h0};
	localparam logic [AXI_AW-1:0] CON1_ADDR = {2'h0, CON1_IDX, 2'h0};
	localparam logic [AXI_AW-1:0] FLAG_ADDR = 12'h130;
	localparam logic [AXI_AW-1:0] MASK_ADDR = 12'h134;
	localparam logic [AXI_AW-1:0] GLOBAL_ADDR = 12'h138;

	// ==================================================
	// Field positions
	localparam int unsigned BIT_ON = 7;
	localparam int unsigned BIT_BELOW = 5;
	localparam int unsigned BIT_STABLE = 4;
	localparam int unsigned BIT_RISE = 1;
	localparam int unsigned BIT_FALL = 0;
	localparam int unsigned BIT_EVT = 0;
	localparam int unsigned SEL_W = 4;

	// ==================================================
	// Reset values and reserved codes
	localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
	localparam logic [SEL_W-1:0] SEL_RSV = 4'hf;
	localparam logic CTRL_RST = 1'h0;

	// ==================================================
	// Types
	typedef enum logic [2:0] {REG_NONE, REG_CON0, REG_CON1, REG_FLAG, REG_MASK, REG_GLOBAL} svm_reg_t;

	typedef struct packed {
		logic below;
		logic ref_ready;
	} svm_ana_in_t;

	typedef struct packed {
		logic enable;
		logic [SEL_W-1:0] trip_code;
	} svm_ana_out_t;

endpackage

// >>> rtl/svm_ctrl.sv
`timescale 1ns/1ps
// ==================================================
// Supply threshold monitor control
module svm_ctrl (
	input logic aclk,
	input logic aresetn,
	input logic por_reset,
	input logic [svm_pkg::AXI_AW-1:0] awaddr,
	input logic awvalid,
	output logic awready,
	input logic [31:0] wdata,
	input logic [3:0] wstrb,
	input logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input logic bready,
	input logic [svm_pkg::AXI_AW-1:0] araddr,
	input logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input logic rready,
	input svm_pkg::svm_ana_in_t ana_in,
	output svm_pkg::svm_ana_out_t ana_out,
	output logic irq,
	output logic wake
);
	import svm_pkg::*;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==================================================
	// Address decode
	function automatic svm_reg_t reg_decode(input logic [AXI_AW-1:0] a);
		case (a)
			CON0_ADDR: reg_decode = REG_CON0;
			CON1_ADDR: reg_decode = REG_CON1;
			FLAG_ADDR: reg_decode = REG_FLAG;
			MASK_ADDR: reg_decode = REG_MASK;
			GLOBAL_ADDR: reg_decode = REG_GLOBAL;
			default: reg_decode = REG_NONE;
		endcase
	endfunction

	// ==================================================
	// Declarations
	logic aw_got_r, aw_got_nxt;
	logic w_got_r, w_got_nxt;
	logic [AXI_AW-1:0] waddr_r, waddr_nxt;
	logic [7:0] wbyte_r, wbyte_nxt;
	logic wlane_r, wlane_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic wr_fire;
	svm_reg_t wr_reg;
	svm_reg_t rd_reg;

	logic on_r, on_nxt;
	logic rise_r, rise_nxt;
	logic fall_r, fall_nxt;
	logic [SEL_W-1:0] sel_r, sel_nxt;
	logic ie_r, ie_nxt;
	logic global_on_r, global_on_nxt;

	logic [1:0] below_sync_r, below_sync_nxt;
	logic [1:0] rdy_sync_r, rdy_sync_nxt;
	logic below_s;
	logic ref_stable;
	logic armed_r, armed_nxt;
	logic prev_below_r, prev_below_nxt;
	logic flag_r, flag_nxt;
	logic flag_clr;
	logic crossing;

	// ==================================================
	// Write channel
	always_comb begin
		awready = !aw_got_r && !bvalid_r;
		wready = !w_got_r && !bvalid_r;
		wr_fire = aw_got_r && w_got_r && !bvalid_r;
		wr_reg = reg_decode(waddr_r);
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		waddr_nxt = waddr_r;
		wbyte_nxt = wbyte_r;
		wlane_nxt = wlane_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (awvalid && awready) begin
			aw_got_nxt = 1'b1;
			waddr_nxt = awaddr;
		end
		if (wvalid && wready) begin
			w_got_nxt = 1'b1;
			wbyte_nxt = wdata[7:0];
			wlane_nxt = wstrb[0];
		end
		if (wr_fire) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			waddr_r <= '0;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			waddr_r <= waddr_nxt;
			wbyte_r <= wbyte_nxt;
			wlane_r <= wlane_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	chk_write_answer: assert property (wr_fire |=> bvalid_r && !awready && !wready)
		else $error("Write response missing after both halves taken");

	// ==================================================
	// Control registers
	always_comb begin
		on_nxt = on_r;
		rise_nxt = rise_r;
		fall_nxt = fall_r;
		sel_nxt = sel_r;
		ie_nxt = ie_r;
		global_on_nxt = global_on_r;
		if (wr_fire && wlane_r) begin
			case (wr_reg)
				REG_CON0: begin
					on_nxt = wbyte_r[BIT_ON];
					rise_nxt = wbyte_r[BIT_RISE];
					fall_nxt = wbyte_r[BIT_FALL];
				end
				REG_CON1: begin
					if (wbyte_r[SEL_W-1:0] != SEL_RSV) begin
						sel_nxt = wbyte_r[SEL_W-1:0];
					end
				end
				REG_MASK: ie_nxt = wbyte_r[BIT_EVT];
				REG_GLOBAL: global_on_nxt = wbyte_r[BIT_EVT];
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_r <= CTRL_RST;
			rise_r <= CTRL_RST;
			fall_r <= CTRL_RST;
			ie_r <= CTRL_RST;
			global_on_r <= CTRL_RST;
			if (por_reset) begin
				sel_r <= SEL_RST;
			end
		end else begin
			on_r <= on_nxt;
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
			sel_r <= sel_nxt;
			ie_r <= ie_nxt;
			global_on_r <= global_on_nxt;
		end
	end

	assign ana_out.trip_code = sel_r;
	assign ana_out.enable = on_r;

	chk_sel_write: assert property (wr_fire && wlane_r && wr_reg == REG_CON1 &&
		wbyte_r[SEL_W-1:0] != SEL_RSV |=> sel_r == $past(wbyte_r[SEL_W-1:0]))
		else $error("Trip level not loaded from write");
	chk_sel_reserved: assert property (##1 sel_r != SEL_RSV)
		else $error("Reserved trip level code held");

	// ==================================================
	// Comparator synchronisers
	always_comb begin
		below_sync_nxt = {below_sync_r[0], ana_in.below};
		rdy_sync_nxt = {rdy_sync_r[0], ana_in.ref_ready};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			below_sync_r <= 2'h0;
			rdy_sync_r <= 2'h0;
		end else begin
			below_sync_r <= below_sync_nxt;
			rdy_sync_r <= rdy_sync_nxt;
		end
	end

	assign below_s = below_sync_r[1];
	assign ref_stable = on_r && rdy_sync_r[1];

	chk_stable_needs_on: assert property (!on_r |-> !ref_stable)
		else $error("Reference stable shown while disabled");

	// ==================================================
	// Crossing detection and event flag
	always_comb begin
		armed_nxt = ref_stable;
		prev_below_nxt = below_s;
		flag_clr = wr_fire && wlane_r && (wr_reg == REG_FLAG) && wbyte_r[BIT_EVT];
		// compare with previous sample, both armed
		// flag on leaving below the limit (rise) or on going below it (fall)
		crossing = armed_r && armed_nxt && (below_s != prev_below_r) &&
			((rise_r && prev_below_r) || (fall_r && !prev_below_r));
		flag_nxt = flag_r;
		if (flag_clr) begin
			flag_nxt = 1'b0;
		end
		if (crossing) begin
			flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed_r <= 1'b0;
			prev_below_r <= 1'b0;
			flag_r <= 1'b0;
		end else begin
			armed_r <= armed_nxt;
			prev_below_r <= prev_below_nxt;
			flag_r <= flag_nxt;
		end
	end

	assign irq = flag_r && ie_r && global_on_r && ref_stable;
	assign wake = flag_r;

	sequence rise_cross_s;
		armed_r && ref_stable && rise_r && prev_below_r && !below_s;
	endsequence
	sequence fall_cross_s;
		armed_r && ref_stable && fall_r && !prev_below_r && below_s;
	endsequence
	sequence flag_held_s;
		flag_r && !flag_clr;
	endsequence

	chk_rise_sets: assert property (rise_cross_s |=> flag_r)
		else $error("Rising crossing did not set flag");
	chk_fall_sets: assert property (fall_cross_s |=> flag_r)
		else $error("Falling crossing did not set flag");
	chk_flag_sticky: assert property (flag_held_s |=> flag_r)
		else $error("Event flag dropped without clear");
	chk_no_event_off: assert property (!on_r && !flag_r && !crossing ##1 !on_r |-> !flag_r)
		else $error("Event flag set while monitor off");
	chk_enable_quiet: assert property ($rose(on_r) && !flag_r |-> !flag_r [*2])
		else $error("Enable alone raised event flag");
	chk_irq_gate: assert property (irq |-> flag_r && ie_r && global_on_r)
		else $error("Interrupt without flag and both enables");
	chk_irq_stable: assert property (!ref_stable |-> !irq)
		else $error("Interrupt raised before reference stable");

	// ==================================================
	// Read channel
	always_comb begin
		arready = !rvalid_r;
		rd_reg = reg_decode(araddr);
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = 32'h0000_0000;
			rresp_nxt = RESP_OKAY;
			case (rd_reg)
				REG_CON0: begin
					rdata_nxt[BIT_ON] = on_r;
					rdata_nxt[BIT_BELOW] = below_s;
					rdata_nxt[BIT_STABLE] = ref_stable;
					rdata_nxt[BIT_RISE] = rise_r;
					rdata_nxt[BIT_FALL] = fall_r;
				end
				REG_CON1: rdata_nxt[SEL_W-1:0] = sel_r;
				REG_FLAG: rdata_nxt[BIT_EVT] = flag_r;
				REG_MASK: rdata_nxt[BIT_EVT] = ie_r;
				REG_GLOBAL: rdata_nxt[BIT_EVT] = global_on_r;
				default: rresp_nxt = RESP_SLVERR;
			endcase
		end else if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	chk_below_read: assert property (arvalid && arready && rd_reg == REG_CON0 |=>
		rvalid_r && rdata_r[BIT_BELOW] == $past(below_s))
		else $error("Below limit bit does not match comparator");
	chk_read_hold: assert property (rvalid_r && !rready |=> rvalid_r && $stable(rdata_r))
		else $error("Read data changed before accepted");

endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
// ==================================================
// Supply monitor bench
module testbench;
	import svm_pkg::*;
	logic aclk = 1'b0, aresetn, por_reset, irq, wake;
	logic [AXI_AW-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	svm_ana_in_t ana_in;
	svm_ana_out_t ana_out;
	int n_errors, samples_checked;

	svm_ctrl svm_ctrl_i (.aclk(aclk), .aresetn(aresetn), .por_reset(por_reset),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ana_in(ana_in), .ana_out(ana_out), .irq(irq), .wake(wake));

	always #2 aclk = ~aclk;

	// ==================================================
	// Helpers
	task stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task tmo;
		n_errors++;
		$display("[ERR] %0t bus answer never came", $time);
		stop_test;
	endtask

	task waitc(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask

	task wr(input logic [AXI_AW-1:0] a, input logic [31:0] v);
		int i;
		logic pa, pw, pb, fa, fw, fb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		for (i = 0; i < 64 && pb; i++) begin
			@(negedge aclk);
			fa = pa && awready;
			fw = pw && wready;
			fb = pb && bvalid;
			r = bresp;
			@(posedge aclk);
			if (fa) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (fw) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
			if (fb) begin
				bready <= 1'b0;
				pb = 1'b0;
			end
		end
		if (pb)
			tmo;
	endtask

	task rd(input logic [AXI_AW-1:0] a);
		int i;
		logic pa, pr, fa, fr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		pa = 1'b1;
		pr = 1'b1;
		for (i = 0; i < 64 && pr; i++) begin
			@(negedge aclk);
			fa = pa && arready;
			fr = pr && rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (fa) begin
				arvalid <= 1'b0;
				pa = 1'b0;
			end
			if (fr) begin
				rready <= 1'b0;
				pr = 1'b0;
			end
		end
		if (pr)
			tmo;
	endtask

	task rchk(input logic [AXI_AW-1:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask

	task ana(input logic b, input logic rr);
		@(posedge aclk);
		ana_in <= {b, rr};
		waitc(6);
	endtask

	task rst(input logic p);
		@(posedge aclk);
		aresetn <= 1'b0;
		por_reset <= p;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		por_reset <= 1'b0;
		waitc(2);
	endtask

	// ==================================================
	// Main sequence
	initial begin
		aresetn = 1'b0;
		por_reset = 1'b1;
		awaddr = '0;
		araddr = '0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		wdata = '0;
		wstrb = 4'h1;
		ana_in = '0;
		n_errors = 0;
		samples_checked = 0;
		rst(1'b1);
		rchk(CON0_ADDR, 32'h0);
		rchk(CON1_ADDR, 32'h0);
		chk(32'(irq), 32'h0);
		rd(12'h200);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(12'h204, 32'h1);
		chk(32'(r), 32'(RESP_SLVERR));
		$display("test reset_and_map finished");
		wr(CON1_ADDR, 32'h5);
		wr(CON1_ADDR, 32'hf);
		rchk(CON1_ADDR, 32'h5);
		chk(32'(ana_out.trip_code), 32'h5);
		wstrb <= 4'h0;
		wr(CON1_ADDR, 32'h3);
		chk(32'(r), 32'(RESP_OKAY));
		wstrb <= 4'h1;
		rchk(CON1_ADDR, 32'h5);
		$display("test trip_level finished");
		ana(1'b0, 1'b1);
		wr(CON0_ADDR, 32'h83);
		wr(FLAG_ADDR, 32'h1);
		waitc(4);
		rchk(CON0_ADDR, 32'h93);
		chk(32'(ana_out.enable), 32'h1);
		wr(CON0_ADDR, 32'h03);
		wr(CON0_ADDR, 32'h83);
		waitc(4);
		rchk(FLAG_ADDR, 32'h0);
		$display("test enable finished");
		wr(MASK_ADDR, 32'h1);
		wr(GLOBAL_ADDR, 32'h1);
		ana(1'b1, 1'b1);
		chk(32'(wake), 32'h1);
		chk(32'(irq), 32'h1);
		rchk(FLAG_ADDR, 32'h1);
		rchk(CON0_ADDR, 32'hb3);
		wr(FLAG_ADDR, 32'h1);
		rchk(FLAG_ADDR, 32'h0);
		ana(1'b0, 1'b1);
		rchk(FLAG_ADDR, 32'h1);
		wr(MASK_ADDR, 32'h0);
		waitc(1);
		chk(32'(irq), 32'h0);
		wr(MASK_ADDR, 32'h1);
		wr(GLOBAL_ADDR, 32'h0);
		waitc(1);
		chk(32'(irq), 32'h0);
		wr(GLOBAL_ADDR, 32'h1);
		ana(1'b0, 1'b0);
		chk(32'(irq), 32'h0);
		chk(32'(wake), 32'h1);
		ana(1'b0, 1'b1);
		wr(FLAG_ADDR, 32'h1);
		$display("test crossings finished");
		wr(CON0_ADDR, 32'h00);
		wr(CON0_ADDR, 32'h82);
		ana(1'b1, 1'b1);
		rchk(FLAG_ADDR, 32'h0);
		ana(1'b0, 1'b1);
		rchk(FLAG_ADDR, 32'h1);
		wr(FLAG_ADDR, 32'h1);
		wr(CON0_ADDR, 32'h03);
		ana(1'b1, 1'b1);
		ana(1'b0, 1'b1);
		rchk(FLAG_ADDR, 32'h0);
		$display("test direction_and_off finished");
		rst(1'b0);
		chk(32'(ana_out.trip_code), 32'h5);
		rchk(CON0_ADDR, 32'h0);
		rst(1'b1);
		rchk(CON1_ADDR, 32'h0);
		$display("test reset_kinds finished");
		stop_test;
	end
endmodule
